// [verilog/fepc_ctrl.sv]
`timescale 1ns/1ps
`include "fepc_cfg.svh"
// =====================================================================
// flash erase and byte program control behind the core's register port
//
// Overview of operation
// - pattern 0x55 erases the selected page
// - pattern 0xAA erases whole array when armed
// - whole-array erase only with debug port enabled
// - other erase command values do nothing
// - arm bit resets clear, writing one arms
// - one arming serves one whole-array erase
// - page select holds pages 0..127, resets zero
// - one page load serves one page erase
// - write enable clear: data moves reach RAM
// - write enable set: data move programs flash
// - write enable self-clears after each byte
// - write enable ignores register writes while interrupts enabled (byte self-clear still applies)
module fepc_ctrl
   import fepc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic int_global_en_i,
   input wire logic debug_port_en_i,
   input wire logic movx_wr_i,
   input wire logic [15:0] movx_addr_i,
   input wire logic [7:0] movx_wdata_i,
   output logic external_data_ram_space_wr_o,
   output logic [15:0] external_data_ram_space_addr_o,
   output logic [7:0] external_data_ram_space_wdata_o,
   input wire logic flash_done_i,
   output logic flash_req_o,
   output fepc_op_t flash_op_o,
   output logic [6:0] flash_page_o,
   output logic [15:0] flash_addr_o,
   output logic [7:0] flash_wdata_o,
   output logic busy_o
);
   // =====================================================================
   // state and decode
   fepc_ctl_st_t st_ff; // registered state
   fepc_ctl_st_t nxt_st; // next state
   logic wr_erase; // write to erase command
   logic wr_wctl; // write to write control
   logic wr_page; // write to page select
   logic page_go; // page erase launch
   logic mass_go; // whole-array erase launch
   logic prog_go; // byte program launch
   logic seq_start; // any launch
   fepc_op_t seq_op; // operation to launch
   logic seq_busy; // sequencer busy
   logic [6:0] wr_page_val; // page field carried by a write
   logic wr_arm_val; // arming bit carried by a write
   logic wr_pwe_val; // write enable bit carried by a write

   // address match for a register write or read
   function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] ref_a);
      sfr_hit = (a == ref_a);
   endfunction : sfr_hit

   // write strobes per register
   always_comb begin
      wr_erase = sfr_wr_i && sfr_hit(sfr_addr_i, `FEPC_ADR_ERASE);
      wr_wctl = sfr_wr_i && sfr_hit(sfr_addr_i, `FEPC_ADR_WCTL);
      wr_page = sfr_wr_i && sfr_hit(sfr_addr_i, `FEPC_ADR_PAGE);
      wr_page_val = sfr_wdata_i[`FEPC_PAGE_MSB:`FEPC_PAGE_LSB];
      wr_arm_val = sfr_wdata_i[`FEPC_WCTL_ARM_BIT];
      wr_pwe_val = sfr_wdata_i[`FEPC_WCTL_PWE_BIT];
   end

   // =====================================================================
   // launch decisions
   always_comb begin
      // page erase needs a fresh page load
      page_go = wr_erase && (sfr_wdata_i == `FEPC_CMD_PAGE) && st_ff.page_ld
         && !seq_busy;
      // whole-array erase needs arming and the debug port
      mass_go = wr_erase && (sfr_wdata_i == `FEPC_CMD_MASS) && st_ff.arm
         && st_ff.dbg_s2 && !seq_busy;
      // any other pattern falls through with no launch
      prog_go = movx_wr_i && st_ff.pwe && !seq_busy;
      seq_start = page_go || mass_go || prog_go;
      if (page_go) begin
         seq_op = FEPC_OP_PAGE;
      end else if (mass_go) begin
         seq_op = FEPC_OP_MASS;
      end else if (prog_go) begin
         seq_op = FEPC_OP_PROG;
      end else begin
         seq_op = FEPC_OP_NONE;
      end
   end

   // =====================================================================
   // next state
   always_comb begin
      nxt_st = st_ff;
      // debug port enable crosses in through two flops
      nxt_st.dbg_s1 = debug_port_en_i;
      nxt_st.dbg_s2 = st_ff.dbg_s1;

      // consume arming and page load once launched
      if (mass_go) begin
         nxt_st.arm = 1'b0;
      end
      if (page_go) begin
         nxt_st.page_ld = 1'b0;
         nxt_st.page = `FEPC_RST_PAGE;
      end
      // write enable clears after every byte move
      if (movx_wr_i && st_ff.pwe) begin
         nxt_st.pwe = 1'b0;
      end

      // register writes come last so a set beats a clear
      if (wr_page) begin
         nxt_st.page = sfr_wdata_i[`FEPC_PAGE_MSB:`FEPC_PAGE_LSB];
         nxt_st.page_ld = 1'b1;
      end
      if (wr_wctl) begin
         nxt_st.arm = sfr_wdata_i[`FEPC_WCTL_ARM_BIT];
         if (!int_global_en_i) begin
            nxt_st.pwe = sfr_wdata_i[`FEPC_WCTL_PWE_BIT];
         end
      end

      // data moves with write enable clear go to RAM space
      nxt_st.external_data_ram_space_wr = movx_wr_i && !st_ff.pwe;
      if (movx_wr_i && !st_ff.pwe) begin
         nxt_st.external_data_ram_space_addr = movx_addr_i;
         nxt_st.external_data_ram_space_wdata = movx_wdata_i;
      end

      // read data: write control shows enable and busy, others zero
      if (sfr_rd_i) begin
         nxt_st.rdata = `FEPC_RST_BYTE;
         if (sfr_hit(sfr_addr_i, `FEPC_ADR_WCTL)) begin
            nxt_st.rdata[`FEPC_WCTL_PWE_BIT] = st_ff.pwe;
            nxt_st.rdata[`FEPC_WCTL_BUSY_BIT] = seq_busy;
         end
      end
   end

   // state register, all constants under reset
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_ff.pwe <= `FEPC_RST_PWE;
         st_ff.arm <= `FEPC_RST_ARM;
         st_ff.page <= `FEPC_RST_PAGE;
         st_ff.page_ld <= 1'b0;
         st_ff.dbg_s1 <= 1'b0;
         st_ff.dbg_s2 <= 1'b0;
         st_ff.external_data_ram_space_wr <= 1'b0;
         st_ff.external_data_ram_space_addr <= `FEPC_RST_ADDR;
         st_ff.external_data_ram_space_wdata <= `FEPC_RST_BYTE;
         st_ff.rdata <= `FEPC_RST_BYTE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================================
   // flash operation sequencer
   fepc_flash_seq u_seq (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .start_i(seq_start),
      .op_i(seq_op),
      .page_i(st_ff.page),
      .addr_i(movx_addr_i),
      .data_i(movx_wdata_i),
      .flash_done_i(flash_done_i),
      .busy_o(seq_busy),
      .flash_req_o(flash_req_o),
      .flash_op_o(flash_op_o),
      .flash_page_o(flash_page_o),
      .flash_addr_o(flash_addr_o),
      .flash_wdata_o(flash_wdata_o)
   );

   // =====================================================================
   // outputs
   assign busy_o = seq_busy;
   assign sfr_rdata_o = st_ff.rdata;
   assign external_data_ram_space_wr_o = st_ff.external_data_ram_space_wr;
   assign external_data_ram_space_addr_o = st_ff.external_data_ram_space_addr;
   assign external_data_ram_space_wdata_o = st_ff.external_data_ram_space_wdata;

   // =====================================================================
   // checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   AST_PAGE_START: assert property (
      wr_erase && sfr_wdata_i == `FEPC_CMD_PAGE && st_ff.page_ld && !busy_o
      |=> flash_req_o && flash_op_o == FEPC_OP_PAGE && flash_page_o == $past(st_ff.page))
      else $error("page erase not launched");

   AST_PAGE_NEEDS_LOAD: assert property (
      $rose(flash_req_o) && flash_op_o == FEPC_OP_PAGE |-> $past(st_ff.page_ld))
      else $error("page erase without page load");

   AST_MASS_START: assert property (
      wr_erase && sfr_wdata_i == `FEPC_CMD_MASS && st_ff.arm && st_ff.dbg_s2 && !busy_o
      |=> flash_req_o && flash_op_o == FEPC_OP_MASS)
      else $error("whole-array erase not launched");

   AST_MASS_DEBUG: assert property (
      $rose(flash_req_o) && flash_op_o == FEPC_OP_MASS |-> $past(st_ff.dbg_s2) && $past(st_ff.arm))
      else $error("whole-array erase without debug port or arming");

   AST_BAD_CMD: assert property (
      wr_erase && sfr_wdata_i != `FEPC_CMD_PAGE && sfr_wdata_i != `FEPC_CMD_MASS
      && !movx_wr_i && !busy_o |=> !flash_req_o)
      else $error("unknown command launched an operation");

   AST_ARM_ONCE: assert property (
      $rose(flash_req_o) && flash_op_o == FEPC_OP_MASS |-> !st_ff.arm || $past(wr_wctl))
      else $error("arming survived a whole-array erase");

   AST_EXTERNAL_DATA_RAM_SPACE_ROUTE: assert property (
      movx_wr_i && !st_ff.pwe |=> external_data_ram_space_wr_o && external_data_ram_space_addr_o == $past(movx_addr_i)
      && !$rose(flash_req_o))
      else $error("data move missed RAM space");

   AST_PROG_ROUTE: assert property (
      movx_wr_i && st_ff.pwe && !busy_o |=> !external_data_ram_space_wr_o && flash_req_o
      && flash_op_o == FEPC_OP_PROG && flash_wdata_o == $past(movx_wdata_i))
      else $error("byte program not launched");

   AST_PWE_CLEAR: assert property (
      movx_wr_i && st_ff.pwe && !wr_wctl |=> !st_ff.pwe ##1 !st_ff.pwe || $past(wr_wctl))
      else $error("write enable not cleared after byte");

   AST_PWE_LOCK: assert property (
      wr_wctl && int_global_en_i && !movx_wr_i |=> st_ff.pwe == $past(st_ff.pwe))
      else $error("write enable changed with interrupts enabled");

   // =====================================================================
   // register effects and refusals

   AST_PAGE_LOAD: assert property (
      wr_page |=> st_ff.page_ld && st_ff.page == $past(wr_page_val))
      else $error("page select not loaded");

   AST_PAGE_UNLOADED: assert property (
      wr_erase && sfr_wdata_i == `FEPC_CMD_PAGE && !st_ff.page_ld && !movx_wr_i && !busy_o
      |=> !flash_req_o)
      else $error("page erase launched without a fresh page");

   AST_PAGE_CONSUME: assert property (
      page_go |=> !st_ff.page_ld && st_ff.page == `FEPC_RST_PAGE)
      else $error("page load survived a page erase");

   AST_ARM_WRITE: assert property (
      wr_wctl |=> st_ff.arm == $past(wr_arm_val))
      else $error("arming bit not written");

   AST_MASS_UNARMED: assert property (
      wr_erase && sfr_wdata_i == `FEPC_CMD_MASS && !st_ff.arm && !movx_wr_i && !busy_o
      |=> !flash_req_o)
      else $error("whole-array erase launched unarmed");

   AST_MASS_NO_DEBUG: assert property (
      wr_erase && sfr_wdata_i == `FEPC_CMD_MASS && !st_ff.dbg_s2 && !movx_wr_i && !busy_o
      |=> !flash_req_o)
      else $error("whole-array erase launched without debug port");

   AST_ARM_KEPT: assert property (
      wr_erase && sfr_wdata_i == `FEPC_CMD_MASS && st_ff.arm && !st_ff.dbg_s2 |=> st_ff.arm)
      else $error("refused whole-array erase dropped the arming");

   AST_PWE_WRITE: assert property (
      wr_wctl && !int_global_en_i |=> st_ff.pwe == $past(wr_pwe_val))
      else $error("write enable not written with interrupts disabled");

   AST_EXTERNAL_DATA_RAM_SPACE_SOURCE: assert property (
      external_data_ram_space_wr_o |-> $past(movx_wr_i) && !$past(st_ff.pwe))
      else $error("ram write without a plain data move");

   AST_PROG_SOURCE: assert property (
      $rose(flash_req_o) && flash_op_o == FEPC_OP_PROG
      |-> $past(movx_wr_i) && $past(st_ff.pwe))
      else $error("byte program without an enabled data move");

   AST_IDLE_OP: assert property (
      !flash_req_o |-> flash_op_o == FEPC_OP_NONE)
      else $error("operation code shown with no request");

   AST_PWE_READBACK: assert property (
      sfr_rd_i && sfr_addr_i == `FEPC_ADR_WCTL
      |=> sfr_rdata_o[`FEPC_WCTL_PWE_BIT] == $past(st_ff.pwe))
      else $error("write enable readback wrong");
endmodule : fepc_ctrl

// [verilog/fepc_cfg.svh]
`ifndef FEPC_CFG_SVH
`define FEPC_CFG_SVH
// =====================================================================
// special function register addresses
`define FEPC_ADR_ERASE 8'h94
`define FEPC_ADR_WCTL 8'hB2
`define FEPC_ADR_PAGE 8'hB7
// =====================================================================
// erase command patterns
`define FEPC_CMD_PAGE 8'h55
`define FEPC_CMD_MASS 8'hAA
// =====================================================================
// field positions
`define FEPC_WCTL_PWE_BIT 0
`define FEPC_WCTL_ARM_BIT 1
`define FEPC_WCTL_BUSY_BIT 7
`define FEPC_PAGE_MSB 7
`define FEPC_PAGE_LSB 1
// =====================================================================
// reset values
`define FEPC_RST_PWE 1'b0
`define FEPC_RST_ARM 1'b0
`define FEPC_RST_PAGE 7'h00
`define FEPC_RST_BYTE 8'h00
`define FEPC_RST_ADDR 16'h0000
`endif

// [verilog/fepc_pkg.sv]
package fepc_pkg;
   // =====================================================================
   // flash operation kinds handed to the sequencer
   typedef enum logic [1:0] {
      FEPC_OP_NONE = 2'b00,
      FEPC_OP_PAGE = 2'b01,
      FEPC_OP_MASS = 2'b10,
      FEPC_OP_PROG = 2'b11
   } fepc_op_t;

   // sequencer states
   typedef enum logic [1:0] {
      FEPC_SQ_IDLE = 2'b00,
      FEPC_SQ_REQ = 2'b01
   } fepc_sq_state_t;

   // =====================================================================
   // sequencer state
   typedef struct packed {
      fepc_sq_state_t state;
      fepc_op_t op;
      logic [6:0] page;
      logic [15:0] addr;
      logic [7:0] data;
   } fepc_seq_st_t;

   // controller state
   typedef struct packed {
      logic pwe;
      logic arm;
      logic [6:0] page;
      logic page_ld;
      logic dbg_s1;
      logic dbg_s2;
      logic external_data_ram_space_wr;
      logic [15:0] external_data_ram_space_addr;
      logic [7:0] external_data_ram_space_wdata;
      logic [7:0] rdata;
   } fepc_ctl_st_t;
endpackage : fepc_pkg

// [verilog/fepc_flash_seq.sv]
`timescale 1ns/1ps
`include "fepc_cfg.svh"
// launches one flash operation and holds the request until the array reports done
module fepc_flash_seq
   import fepc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic start_i,
   input wire fepc_op_t op_i,
   input wire logic [6:0] page_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic flash_done_i,
   output logic busy_o,
   output logic flash_req_o,
   output fepc_op_t flash_op_o,
   output logic [6:0] flash_page_o,
   output logic [15:0] flash_addr_o,
   output logic [7:0] flash_wdata_o
);
   // =====================================================================
   // state
   fepc_seq_st_t st_ff; // registered state
   fepc_seq_st_t nxt_st; // next state

   // next state: accept a start only when idle
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.state)
         FEPC_SQ_IDLE: begin
            if (start_i) begin
               nxt_st.state = FEPC_SQ_REQ;
               nxt_st.op = op_i;
               nxt_st.page = page_i;
               nxt_st.addr = addr_i;
               nxt_st.data = data_i;
            end
         end
         FEPC_SQ_REQ: begin
            // request stands until the array finishes
            if (flash_done_i) begin
               nxt_st.state = FEPC_SQ_IDLE;
               nxt_st.op = FEPC_OP_NONE;
            end
         end
         default: begin
            nxt_st.state = FEPC_SQ_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_ff <= '{FEPC_SQ_IDLE, FEPC_OP_NONE, `FEPC_RST_PAGE, `FEPC_RST_ADDR, `FEPC_RST_BYTE};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================================
   // outputs
   assign busy_o = (st_ff.state != FEPC_SQ_IDLE);
   assign flash_req_o = (st_ff.state == FEPC_SQ_REQ);
   assign flash_op_o = st_ff.op;
   assign flash_page_o = st_ff.page;
   assign flash_addr_o = st_ff.addr;
   assign flash_wdata_o = st_ff.data;

   // =====================================================================
   // checks
   AST_REQ_HOLD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      flash_req_o && !flash_done_i |=> flash_req_o && $stable(flash_op_o))
      else $error("flash request dropped before done");
endmodule : fepc_flash_seq

// [tb/fepc_flash_model.sv]
`timescale 1ns/1ps
// =====================================================================
// flash array stand-in: answers each request after a chosen delay
module fepc_flash_model (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic flash_req_i,
   input wire logic [3:0] delay_i,
   output logic flash_done_o
);
   logic [3:0] cnt_ff; // cycles spent on the current operation
   // done is a single pulse, never repeated while the request falls
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_ff <= 4'h0;
         flash_done_o <= 1'b0;
      end else begin
         flash_done_o <= flash_req_i && !flash_done_o && (cnt_ff >= delay_i);
         cnt_ff <= (flash_req_i && !flash_done_o) ? cnt_ff + 4'h1 : 4'h0;
      end
   end
endmodule : fepc_flash_model

// [tb/fepc_ctrl_tb_top.sv]
`timescale 1ns/1ps
// =====================================================================
// self-checking bench: drivers note results, a monitor compares them
module fepc_ctrl_tb_top
   import fepc_pkg::*;
;
   logic mclk_i = 1'b0, resetn_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
   logic int_global_en_i = 1'b0, debug_port_en_i = 1'b0, movx_wr_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, movx_wdata_i = 8'h00;
   logic [15:0] movx_addr_i = 16'h0000;
   logic [3:0] dly = 4'h2; // flash answer delay
   logic [7:0] sfr_rdata_o, external_data_ram_space_wdata_o, flash_wdata_o;
   logic [15:0] external_data_ram_space_addr_o, flash_addr_o;
   logic [6:0] flash_page_o;
   logic external_data_ram_space_wr_o, flash_done_i, flash_req_o, busy_o, req_q = 1'b0, rd_q = 1'b0;
   fepc_op_t flash_op_o;
   logic [32:0] fq[$]; // expected requests: op, page, addr, data
   logic [23:0] xq[$]; // expected ram writes: addr, data
   logic [7:0] rq[$]; // expected read data
   int error_cnt = 0, comparisons = 0, cycles = 0;
   fepc_ctrl dut (.mclk_i, .resetn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
      .sfr_rdata_o, .int_global_en_i, .debug_port_en_i, .movx_wr_i, .movx_addr_i,
      .movx_wdata_i, .external_data_ram_space_wr_o, .external_data_ram_space_addr_o, .external_data_ram_space_wdata_o, .flash_done_i, .flash_req_o,
      .flash_op_o, .flash_page_o, .flash_addr_o, .flash_wdata_o, .busy_o);
   fepc_flash_model flash (.mclk_i, .resetn_i, .flash_req_i(flash_req_o),
      .delay_i(dly), .flash_done_o(flash_done_i));
   // =====================================================================
   // clock and hang guard
   initial begin
      forever #10 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad("run timed out");
         finish_test();
      end
   end
   // =====================================================================
   // report and compare tasks
   task automatic bad(input string msg);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask : bad
   task automatic cmp_flash(input logic [32:0] e);
      comparisons++;
      if (flash_op_o !== e[32:31] || (e[32:31] == 2'h1 && flash_page_o !== e[30:24]) ||
         (e[32:31] == 2'h3 && {flash_addr_o, flash_wdata_o} !== e[23:0])) bad("flash request");
   endtask : cmp_flash
   task automatic cmp_external_data_ram_space(input logic [23:0] e);
      comparisons++;
      if ({external_data_ram_space_addr_o, external_data_ram_space_wdata_o} !== e) bad("ram write");
   endtask : cmp_external_data_ram_space
   task automatic cmp_rd(input logic [7:0] e);
      comparisons++;
      if (sfr_rdata_o !== e) bad("read data");
   endtask : cmp_rd
   task automatic finish_test();
      if (fq.size() + xq.size() + rq.size() != 0) bad("result missing");
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // =====================================================================
   // monitor: each appearing result takes the oldest note of its kind
   // sampled mid-cycle, where registered outputs have settled
   always @(negedge mclk_i) begin
      if (flash_req_o === 1'b1 && req_q !== 1'b1) begin
         if (fq.size() == 0) bad("flash request");
         else cmp_flash(fq.pop_front());
      end
      if (external_data_ram_space_wr_o === 1'b1) begin
         if (xq.size() == 0) bad("ram write");
         else cmp_external_data_ram_space(xq.pop_front());
      end
      if (rd_q === 1'b1) begin
         if (rq.size() == 0) bad("read data");
         else cmp_rd(rq.pop_front());
      end
      req_q = flash_req_o;
      rd_q = sfr_rd_i;
   end
   // =====================================================================
   // bus driver tasks, entered and left just after a rising edge
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      idle(1);
      sfr_wr_i = 1'b0;
      // one quiet edge so a following write never re-raises the strobe at once
      idle(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      idle(1);
      sfr_rd_i = 1'b0;
      idle(1);
   endtask : rd
   task automatic mv(input logic [15:0] a, input logic [7:0] d);
      movx_addr_i = a;
      movx_wdata_i = d;
      movx_wr_i = 1'b1;
      idle(1);
      movx_wr_i = 1'b0;
   endtask : mv
   task automatic wait_idle();
      int n;
      n = 0;
      idle(2);
      while (busy_o !== 1'b0 && n < 40) begin
         idle(1);
         n++;
      end
      if (n == 40) bad("flash never finished");
      dly = 4'($urandom_range(9));
   endtask : wait_idle
   // =====================================================================
   // main sequence
   initial begin
      logic [7:0] pat [6] = '{8'h00, 8'h54, 8'h56, 8'hA9, 8'hAB, 8'hFF};
      logic [6:0] p;
      logic [15:0] a;
      logic [7:0] d;
      void'($urandom(32'h38a8));
      idle(3);
      resetn_i = 1'b1;
      // reset values, write-only and unmapped places read zero
      rd(8'hB2, 8'h00);
      rd(8'hB7, 8'h00);
      rd(8'h94, 8'h00);
      rd(8'h10, 8'h00);
      wr(8'h94, 8'h55); // no page loaded, no erase
      wait_idle();
      // page erase at both ends of the range and at random pages
      for (int i = 0; i < 6; i++) begin
         p = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
         wr(8'hB7, {p, 1'($urandom)});
         fq.push_back({2'h1, p, 24'h00_0000});
         wr(8'h94, 8'h55);
         wait_idle();
         wr(8'h94, 8'h55); // not reloaded, no erase
         wait_idle();
      end
      // other patterns do nothing and keep the loaded page
      wr(8'hB7, 8'h2A);
      for (int i = 0; i < 6; i++) wr(8'h94, pat[i]);
      wait_idle();
      fq.push_back({2'h1, 7'h15, 24'h00_0000});
      wr(8'h94, 8'h55);
      rd(8'hB2, 8'h80); // busy shown while the erase runs
      wait_idle();
      // whole-array erase: arming, debug port, one use per arming
      debug_port_en_i = 1'b1;
      idle(3);
      wr(8'h94, 8'hAA); // unarmed
      wait_idle();
      wr(8'hB2, 8'h02);
      fq.push_back({2'h2, 31'h0000_0000});
      wr(8'h94, 8'hAA);
      wait_idle();
      wr(8'h94, 8'hAA);
      wait_idle();
      debug_port_en_i = 1'b0;
      wr(8'hB2, 8'h02);
      idle(3);
      wr(8'h94, 8'hAA);
      wait_idle();
      debug_port_en_i = 1'b1;
      idle(3);
      fq.push_back({2'h2, 31'h0000_0000});
      wr(8'h94, 8'hAA); // arming kept
      wait_idle();
      // byte program, self-clear, then a plain ram move
      for (int i = 0; i < 4; i++) begin
         a = 16'($urandom);
         d = 8'($urandom);
         wr(8'hB2, 8'h01);
         rd(8'hB2, 8'h01);
         fq.push_back({2'h3, 7'h00, a, d});
         mv(a, d);
         wait_idle();
         rd(8'hB2, 8'h00);
         xq.push_back({~a, d});
         mv(~a, d);
         wait_idle();
      end
      // interrupts enabled freeze the write enable both ways
      int_global_en_i = 1'b1;
      wr(8'hB2, 8'h01);
      rd(8'hB2, 8'h00);
      xq.push_back(24'h12_3456);
      mv(16'h1234, 8'h56);
      int_global_en_i = 1'b0;
      wr(8'hB2, 8'h01);
      int_global_en_i = 1'b1;
      wr(8'hB2, 8'h00);
      rd(8'hB2, 8'h01);
      fq.push_back({2'h3, 7'h00, 24'hBE_EF5A});
      mv(16'hBEEF, 8'h5A);
      wait_idle();
      // a second reset drops arming, page and write enable
      int_global_en_i = 1'b0;
      wr(8'hB2, 8'h03);
      wr(8'hB7, 8'h08);
      resetn_i = 1'b0;
      idle(3);
      resetn_i = 1'b1;
      idle(3);
      rd(8'hB2, 8'h00);
      wr(8'h94, 8'h55);
      wait_idle();
      wr(8'h94, 8'hAA);
      wait_idle();
      finish_test();
   end
endmodule : fepc_ctrl_tb_top
